// ### verilog/ulf_defs.vh
// Constants for the serial channel: offsets, field positions, reset values, counts
`ifndef ULF_DEFS_VH
`define ULF_DEFS_VH
// ==========================================================================
// Register offsets
`define ULF_OFS_DATA 3'h0
`define ULF_OFS_IEN 3'h1
`define ULF_OFS_IDQ 3'h2
`define ULF_OFS_LFMT 3'h3
`define ULF_OFS_MCTL 3'h4
`define ULF_OFS_LST 3'h5
`define ULF_OFS_MST 3'h6
`define ULF_OFS_SPAD 3'h7
// ==========================================================================
// Line-format fields
`define ULF_LF_STOP 2
`define ULF_LF_PEN 3
`define ULF_LF_EPS 4
`define ULF_LF_STICK 5
`define ULF_LF_BRK 6
`define ULF_LF_DIVSEL 7
`define ULF_WLS_5 2'h0
`define ULF_WLS_6 2'h1
`define ULF_WLS_7 2'h2
// ==========================================================================
// Interrupt enable fields and identity codes
`define ULF_IE_RDA 0
`define ULF_IE_HOLD 1
`define ULF_IE_RLS 2
`define ULF_ID_RLS 8'h06
`define ULF_ID_RDA 8'h04
`define ULF_ID_HOLD 8'h02
`define ULF_ID_NONE 8'h01
// ==========================================================================
// Reset values
`define ULF_RST_BYTE 8'h00
`define ULF_RST_IEN 4'h0
`define ULF_RST_MCTL 5'h00
`define ULF_RST_DIV 16'h0001
// ==========================================================================
// Baud tick counts, last tick index of each bit period
`define ULF_TICK_HALF 5'h07
`define ULF_TICK_BIT 5'h0F
`define ULF_TICK_1P5 5'h17
`define ULF_TICK_TWO 5'h1F
`define ULF_DIV_ONE 16'h0001
`endif

// ### verilog/ulf_uart_channel.v
// One serial channel: register decode, baud generator, framed transmitter and receiver
`include "ulf_defs.vh"
`default_nettype none
module ulf_uart_channel (
  input wire sys_clk,
  input wire resetn,
  input wire aen,
  input wire [2:0] bus_addr,
  input wire bus_rd,
  input wire bus_wr,
  input wire [7:0] bus_wdata,
  output reg [7:0] bus_rdata,
  input wire serial_in_pin,
  output reg serial_out_pin,
  output reg baud_clock_out
);

  // ========================================================================
  // State codes, one-hot
  localparam [4:0] S_IDLE = 5'b00001;
  localparam [4:0] S_START = 5'b00010;
  localparam [4:0] S_DATA = 5'b00100;
  localparam [4:0] S_PAR = 5'b01000;
  localparam [4:0] S_STOP = 5'b10000;

  reg [7:0] line_format_reg;
  reg [3:0] interrupt_enables_reg;
  reg [4:0] modem_control_reg;
  reg [7:0] scratch_pad_reg;
  reg [7:0] queue_control_reg;
  reg [15:0] divisor_reg;
  reg [15:0] baud_cnt_reg;
  reg [7:0] transmit_holding_reg;
  reg [7:0] receive_buffer_reg;
  reg tx_holding_empty_reg;
  reg hold_evt_reg;
  reg data_ready_reg, overrun_reg, parity_err_reg, framing_err_reg, break_int_reg;
  reg [4:0] tx_state_reg;
  reg [4:0] tx_tick_reg;
  reg [2:0] tx_bits_reg;
  reg [7:0] tx_shift_reg;
  reg tx_par_reg;
  reg tx_line_reg;
  reg [4:0] rx_state_reg;
  reg [4:0] rx_tick_reg;
  reg [2:0] rx_bits_reg;
  reg [7:0] rx_shift_reg;
  reg rx_par_reg, rx_parbit_reg, rx_ones_reg;
  reg rx_meta_reg, rx_sync_reg, rx_prev_reg;

  wire div_access = line_format_reg[`ULF_LF_DIVSEL];
  wire [1:0] wls = line_format_reg[1:0];
  wire pen = line_format_reg[`ULF_LF_PEN];
  wire eps = line_format_reg[`ULF_LF_EPS];
  wire stick = line_format_reg[`ULF_LF_STICK];

  // ========================================================================
  // Bus decode
  // enable gating
  wire acc_rd = bus_rd & ~aen;
  wire acc_wr = bus_wr & ~aen;
  wire div_sel = div_access & (bus_addr == `ULF_OFS_DATA || bus_addr == `ULF_OFS_IEN);
  wire hold_wr = acc_wr & ~div_access & (bus_addr == `ULF_OFS_DATA);
  wire rxbuf_rd = acc_rd & ~div_access & (bus_addr == `ULF_OFS_DATA);
  wire ident_rd = acc_rd & (bus_addr == `ULF_OFS_IDQ);
  wire state_rd = acc_rd & (bus_addr == `ULF_OFS_LST);
  wire div_wr = acc_wr & div_sel;

  // Interrupt identity, line status first, then data, then holding empty
  wire line_err = overrun_reg | parity_err_reg | framing_err_reg | break_int_reg;
  reg [7:0] ident_val;
  always @* begin
    if (interrupt_enables_reg[`ULF_IE_RLS] & line_err) begin
      ident_val = `ULF_ID_RLS;
    end else if (interrupt_enables_reg[`ULF_IE_RDA] & data_ready_reg) begin
      ident_val = `ULF_ID_RDA;
    end else if (interrupt_enables_reg[`ULF_IE_HOLD] & hold_evt_reg) begin
      ident_val = `ULF_ID_HOLD;
    end else begin
      ident_val = `ULF_ID_NONE;
    end
  end

  wire tx_all_empty = tx_holding_empty_reg & tx_state_reg[0];
  wire [7:0] state_val = {1'b0, tx_all_empty, tx_holding_empty_reg, break_int_reg,
                        framing_err_reg, parity_err_reg, overrun_reg, data_ready_reg};

  // Read mux; unused modem inputs read as zero
  reg [7:0] rd_mux;
  always @* begin
    case (bus_addr)
      `ULF_OFS_DATA: rd_mux = div_access ? divisor_reg[7:0] : receive_buffer_reg;
      `ULF_OFS_IEN: rd_mux = div_access ? divisor_reg[15:8] : {4'h0, interrupt_enables_reg};
      `ULF_OFS_IDQ: rd_mux = ident_val;
      `ULF_OFS_LFMT: rd_mux = line_format_reg;
      `ULF_OFS_MCTL: rd_mux = {3'h0, modem_control_reg};
      `ULF_OFS_LST: rd_mux = state_val;
      `ULF_OFS_MST: rd_mux = `ULF_RST_BYTE;
      default: rd_mux = scratch_pad_reg;
    endcase
  end

  // Read data is registered; it holds until the next read
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      bus_rdata <= `ULF_RST_BYTE;
    end else if (acc_rd) begin
      bus_rdata <= rd_mux;
    end
  end

  // ========================================================================
  // Control registers
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      line_format_reg <= `ULF_RST_BYTE;
      interrupt_enables_reg <= `ULF_RST_IEN;
      modem_control_reg <= `ULF_RST_MCTL;
      scratch_pad_reg <= `ULF_RST_BYTE;
      queue_control_reg <= `ULF_RST_BYTE;
      divisor_reg <= `ULF_RST_DIV;
    end else if (acc_wr) begin
      case (bus_addr)
        `ULF_OFS_DATA: begin
          if (div_access) begin
            divisor_reg[7:0] <= bus_wdata;
          end
        end
        `ULF_OFS_IEN: begin
          if (div_access) begin
            divisor_reg[15:8] <= bus_wdata;
          end else begin
            interrupt_enables_reg <= bus_wdata[3:0];
          end
        end
        // Queue control is kept but no queue exists behind it
        `ULF_OFS_IDQ: queue_control_reg <= bus_wdata;
        `ULF_OFS_LFMT: line_format_reg <= bus_wdata;
        `ULF_OFS_MCTL: modem_control_reg <= bus_wdata[4:0];
        `ULF_OFS_SPAD: scratch_pad_reg <= bus_wdata;
        default: scratch_pad_reg <= scratch_pad_reg;
      endcase
    end
  end

  // ========================================================================
  // Baud generator, one tick per sixteenth of a bit
  wire [15:0] div_new = (bus_addr == `ULF_OFS_DATA) ? {divisor_reg[15:8], bus_wdata}
                                                    : {bus_wdata, divisor_reg[7:0]};
  wire baud_tick = (baud_cnt_reg == `ULF_DIV_ONE);
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      baud_cnt_reg <= `ULF_RST_DIV;
      baud_clock_out <= 1'b0;
    end else begin
      if (div_wr) begin
        baud_cnt_reg <= div_new;
      end else if (baud_tick) begin
        baud_cnt_reg <= divisor_reg;
      end else begin
        baud_cnt_reg <= baud_cnt_reg - `ULF_DIV_ONE;
      end
      baud_clock_out <= div_access & baud_tick;
    end
  end

  // Parity bit for a given xor of the data bits
  function par_bit;
    input data_xor;
    input even_sel;
    input stick_on;
    begin
      if (stick_on) begin
        par_bit = ~even_sel;
      end else begin
        par_bit = even_sel ? data_xor : ~data_xor;
      end
    end
  endfunction

  // ========================================================================
  // Transmitter
  // data length
  wire [2:0] last_bit = {1'b0, wls} + 3'h4;
  wire [4:0] stop_last = ~line_format_reg[`ULF_LF_STOP] ? `ULF_TICK_BIT :
                         (wls == `ULF_WLS_5) ? `ULF_TICK_1P5 : `ULF_TICK_TWO;
  // Loading is held off during a holding write so the new byte is never lost
  wire tx_load = tx_state_reg[0] & ~tx_holding_empty_reg & ~hold_wr;
  wire tx_bit_end = baud_tick & (tx_tick_reg == `ULF_TICK_BIT);

  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      tx_state_reg <= S_IDLE;
      tx_tick_reg <= 5'h00;
      tx_bits_reg <= 3'h0;
      tx_shift_reg <= `ULF_RST_BYTE;
      tx_par_reg <= 1'b0;
      tx_line_reg <= 1'b1;
      transmit_holding_reg <= `ULF_RST_BYTE;
      tx_holding_empty_reg <= 1'b1;
    end else begin
      if (hold_wr) begin
        transmit_holding_reg <= bus_wdata;
        tx_holding_empty_reg <= 1'b0;
      end else if (tx_load) begin
        tx_holding_empty_reg <= 1'b1;
      end
      if (baud_tick) begin
        tx_tick_reg <= tx_tick_reg + 5'h01;
      end
      case (tx_state_reg)
        S_IDLE: begin
          tx_line_reg <= 1'b1;
          if (tx_load) begin
            tx_shift_reg <= transmit_holding_reg;
            tx_line_reg <= 1'b0;
            tx_tick_reg <= 5'h00;
            tx_bits_reg <= 3'h0;
            tx_par_reg <= 1'b0;
            tx_state_reg <= S_START;
          end
        end
        S_START: begin
          if (tx_bit_end) begin
            tx_line_reg <= tx_shift_reg[0];
            tx_tick_reg <= 5'h00;
            tx_state_reg <= S_DATA;
          end
        end
        S_DATA: begin
          if (tx_bit_end) begin
            tx_tick_reg <= 5'h00;
            tx_par_reg <= tx_par_reg ^ tx_shift_reg[0];
            tx_shift_reg <= {1'b0, tx_shift_reg[7:1]};
            tx_bits_reg <= tx_bits_reg + 3'h1;
            if (tx_bits_reg == last_bit) begin
              if (pen) begin
                tx_line_reg <= par_bit(tx_par_reg ^ tx_shift_reg[0], eps, stick);
                tx_state_reg <= S_PAR;
              end else begin
                tx_line_reg <= 1'b1;
                tx_state_reg <= S_STOP;
              end
            end else begin
              tx_line_reg <= tx_shift_reg[1];
            end
          end
        end
        S_PAR: begin
          if (tx_bit_end) begin
            tx_tick_reg <= 5'h00;
            tx_line_reg <= 1'b1;
            tx_state_reg <= S_STOP;
          end
        end
        S_STOP: begin
          if (baud_tick & (tx_tick_reg == stop_last)) begin
            tx_state_reg <= S_IDLE;
          end
        end
        default: tx_state_reg <= S_IDLE;
      endcase
    end
  end

  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      serial_out_pin <= 1'b1;
    end else begin
      serial_out_pin <= tx_line_reg & ~line_format_reg[`ULF_LF_BRK];
    end
  end

  // ========================================================================
  // Receiver, line input passes two flip-flops first
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      rx_meta_reg <= 1'b1;
      rx_sync_reg <= 1'b1;
      rx_prev_reg <= 1'b1;
    end else begin
      rx_meta_reg <= serial_in_pin;
      rx_sync_reg <= rx_meta_reg;
      rx_prev_reg <= rx_sync_reg;
    end
  end

  wire rx_mid = baud_tick & (rx_tick_reg == `ULF_TICK_BIT);
  wire rx_done = rx_state_reg[4] & rx_mid;
  // Shifted in from the top, so short characters need aligning down
  reg [7:0] rx_aligned;
  always @* begin
    case (wls)
      `ULF_WLS_5: rx_aligned = {3'h0, rx_shift_reg[7:3]};
      `ULF_WLS_6: rx_aligned = {2'h0, rx_shift_reg[7:2]};
      `ULF_WLS_7: rx_aligned = {1'h0, rx_shift_reg[7:1]};
      default: rx_aligned = rx_shift_reg;
    endcase
  end

  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      rx_state_reg <= S_IDLE;
      rx_tick_reg <= 5'h00;
      rx_bits_reg <= 3'h0;
      rx_shift_reg <= `ULF_RST_BYTE;
      rx_par_reg <= 1'b0;
      rx_parbit_reg <= 1'b0;
      rx_ones_reg <= 1'b0;
    end else begin
      if (baud_tick) begin
        rx_tick_reg <= rx_tick_reg + 5'h01;
      end
      case (rx_state_reg)
        S_IDLE: begin
          if (rx_prev_reg & ~rx_sync_reg) begin
            rx_tick_reg <= 5'h00;
            rx_bits_reg <= 3'h0;
            rx_par_reg <= 1'b0;
            rx_parbit_reg <= 1'b0;
            rx_ones_reg <= 1'b0;
            rx_state_reg <= S_START;
          end
        end
        S_START: begin
          // Half a bit in, a line back high is taken as a glitch
          if (baud_tick & (rx_tick_reg == `ULF_TICK_HALF)) begin
            rx_tick_reg <= 5'h00;
            rx_state_reg <= rx_sync_reg ? S_IDLE : S_DATA;
          end
        end
        S_DATA: begin
          if (rx_mid) begin
            rx_tick_reg <= 5'h00;
            rx_shift_reg <= {rx_sync_reg, rx_shift_reg[7:1]};
            rx_par_reg <= rx_par_reg ^ rx_sync_reg;
            rx_ones_reg <= rx_ones_reg | rx_sync_reg;
            rx_bits_reg <= rx_bits_reg + 3'h1;
            if (rx_bits_reg == last_bit) begin
              rx_state_reg <= pen ? S_PAR : S_STOP;
            end
          end
        end
        S_PAR: begin
          if (rx_mid) begin
            rx_tick_reg <= 5'h00;
            rx_parbit_reg <= rx_sync_reg;
            rx_ones_reg <= rx_ones_reg | rx_sync_reg;
            rx_state_reg <= S_STOP;
          end
        end
        S_STOP: begin
          if (rx_mid) begin
            rx_state_reg <= S_IDLE;
          end
        end
        default: rx_state_reg <= S_IDLE;
      endcase
    end
  end

  // ========================================================================
  // Line status flags; a new event wins over a clearing read
  wire rx_perr = pen & (rx_parbit_reg != par_bit(rx_par_reg, eps, stick));
  wire rx_brk = ~rx_ones_reg & ~rx_sync_reg;
  wire hold_evt_set = tx_load;
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      receive_buffer_reg <= `ULF_RST_BYTE;
      data_ready_reg <= 1'b0;
      overrun_reg <= 1'b0;
      parity_err_reg <= 1'b0;
      framing_err_reg <= 1'b0;
      break_int_reg <= 1'b0;
      hold_evt_reg <= 1'b0;
    end else begin
      if (rx_done) begin
        receive_buffer_reg <= rx_aligned;
      end
      data_ready_reg <= rx_done | (data_ready_reg & ~rxbuf_rd);
      overrun_reg <= (rx_done & data_ready_reg & ~rxbuf_rd) | (overrun_reg & ~state_rd);
      parity_err_reg <= (rx_done & rx_perr) | (parity_err_reg & ~state_rd);
      framing_err_reg <= (rx_done & ~rx_sync_reg) | (framing_err_reg & ~state_rd);
      break_int_reg <= (rx_done & rx_brk) | (break_int_reg & ~state_rd);
      hold_evt_reg <= hold_evt_set |
                      (hold_evt_reg & ~hold_wr & ~(ident_rd & (ident_val == `ULF_ID_HOLD)));
    end
  end

endmodule // ulf_uart_channel
`default_nettype wire

// ### sim/ulf_channel_monitor.sv
// Port checker for the serial channel: decode, break, baud output and start bit
`default_nettype none
module ulf_channel_monitor (
  input wire sys_clk,
  input wire resetn,
  input wire aen,
  input wire [2:0] bus_addr,
  input wire bus_rd,
  input wire bus_wr,
  input wire [7:0] bus_wdata,
  input wire [7:0] bus_rdata,
  input wire serial_in_pin,
  input wire serial_out_pin,
  input wire baud_clock_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  // ==========================================================================
  // Shadow of host-written registers
  reg [7:0] lf_reg;
  reg [7:0] pad_reg;
  reg [15:0] div_reg;
  wire take_wr = !aen && bus_wr;
  wire take_rd = !aen && bus_rd;
  // Strobes with aen high never reach the shadow, like the real decode
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      lf_reg <= 8'h00;
      pad_reg <= 8'h00;
      div_reg <= 16'h0001;
    end else if (take_wr) begin
      if (bus_addr == 3'h3) lf_reg <= bus_wdata;
      if (bus_addr == 3'h7) pad_reg <= bus_wdata;
      if (bus_addr == 3'h0 && lf_reg[7]) div_reg[7:0] <= bus_wdata;
      if (bus_addr == 3'h1 && lf_reg[7]) div_reg[15:8] <= bus_wdata;
    end
  end
  // ==========================================================================
  // Assertions
  property p_aen_ignore; aen && bus_rd |=> $stable(bus_rdata); endproperty
  a_aen_ignore: assert property (p_aen_ignore) else $error("read taken with aen high");
  property p_div_read;
    take_rd && bus_addr[2:1] == 2'b00 && lf_reg[7] |=>
      bus_rdata == ($past(bus_addr[0]) ? $past(div_reg[15:8]) : $past(div_reg[7:0]));
  endproperty
  a_div_read: assert property (p_div_read) else $error("divisor byte read wrong");
  property p_ien_high; take_rd && bus_addr == 3'h1 && !lf_reg[7] |=> bus_rdata[7:4] == 4'h0;
  endproperty
  a_ien_high: assert property (p_ien_high) else $error("enable upper bits not zero");
  property p_lf_read; take_rd && bus_addr == 3'h3 |=> bus_rdata == $past(lf_reg); endproperty
  a_lf_read: assert property (p_lf_read) else $error("line format read wrong");
  property p_scr_read; take_rd && bus_addr == 3'h7 |=> bus_rdata == $past(pad_reg); endproperty
  a_scr_read: assert property (p_scr_read) else $error("scratch read wrong");
  // Two cycles of settling allowed for the output register chain
  property p_brk_low; lf_reg[6] && $past(lf_reg[6]) && $past(lf_reg[6], 2) |-> !serial_out_pin;
  endproperty
  a_brk_low: assert property (p_brk_low) else $error("serial output high in break");
  property p_baud_clock_out_off;
    !lf_reg[7] && !$past(lf_reg[7]) && !$past(lf_reg[7], 2) |-> !baud_clock_out;
  endproperty
  a_baud_clock_out_off: assert property (p_baud_clock_out_off) else $error("baud output with select clear");
  property p_start_len; $fell(serial_out_pin) && !lf_reg[6] |=> !serial_out_pin [*8];
  endproperty
  a_start_len: assert property (p_start_len) else $error("start bit too short");
endmodule // ulf_channel_monitor
bind ulf_uart_channel ulf_channel_monitor u_mon (.sys_clk, .resetn, .aen, .bus_addr, .bus_rd,
  .bus_wr, .bus_wdata, .bus_rdata, .serial_in_pin, .serial_out_pin, .baud_clock_out);
`default_nettype wire

// ### sim/ulf_serial_partner.sv
// Remote serial peer: catches frames from the channel and sends frames to it
`default_nettype none
module ulf_serial_partner (
  input wire logic sys_clk,
  input wire logic line_from_dut,
  output var logic line_to_dut
);
  timeunit 1ns;
  timeprecision 1ps;
  // Divisor 1 gives one tick per clock, so a bit lasts 16 clocks
  localparam int BIT_CYC = 16;
  initial line_to_dut = 1'b1;
  // Waits sample 1 ns after the edge so the channel's register has settled
  task automatic tick(input int k);
    repeat (k) begin
      @(posedge sys_clk);
      #1;
    end
  endtask
  // ==========================================================================
  // lsb first framing
  task automatic send_frame(input logic [11:0] bits, input int n);
    tick(1);
    for (int i = 0; i < n; i++) begin
      line_to_dut = bits[i];
      tick(BIT_CYC);
    end
    line_to_dut = 1'b1;
  endtask
  task automatic catch_frame(input int n, output logic [8:0] bits, output int stop_cyc,
                             output logic ok);
    int w;
    ok = 1'b0;
    bits = 9'h000;
    stop_cyc = 0;
    for (w = 0; w < 4000 && line_from_dut; w++) tick(1);
    if (line_from_dut) return;
    tick(BIT_CYC / 2);
    ok = !line_from_dut;
    for (int i = 0; i < n; i++) begin
      tick(BIT_CYC);
      bits[i] = line_from_dut;
    end
    tick(BIT_CYC / 2);
    // Stop length is measured up to the next start; idle line ends at the cap
    while (line_from_dut && stop_cyc < 40) begin
      tick(1);
      stop_cyc++;
    end
  endtask
endmodule // ulf_serial_partner
`default_nettype wire

// ### sim/test_uart_line_format_regmap.sv
// Bench for the serial channel: register decode, framing, break and receive
`default_nettype none
module test_uart_line_format_regmap;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk = 1'b0, resetn = 1'b0, aen = 1'b0, bus_rd = 1'b0, bus_wr = 1'b0;
  logic [2:0] bus_addr = 3'h0;
  logic [7:0] bus_wdata = 8'h00;
  wire [7:0] bus_rdata;
  wire serial_in_pin, serial_out_pin, baud_clock_out;
  int err_count = 0, cmp_count = 0;
  logic [2:0] ro [8] = '{3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h6, 3'h7, 3'h0};
  logic [7:0] rv [8] = '{8'h00, 8'h01, 8'h00, 8'h00, 8'h60, 8'h00, 8'h00, 8'h00};
  // Format cases: line format value, then character
  logic [7:0] fl [6] = '{8'h03, 8'h04, 8'h1A, 8'h0D, 8'h2B, 8'h3B};
  logic [7:0] fd [6] = '{8'hA5, 8'h15, 8'h4B, 8'h2C, 8'h81, 8'hFE};
  ulf_uart_channel DUT (.sys_clk, .resetn, .aen, .bus_addr, .bus_rd, .bus_wr, .bus_wdata,
    .bus_rdata, .serial_in_pin, .serial_out_pin, .baud_clock_out);
  ulf_serial_partner peer (.sys_clk, .line_from_dut(serial_out_pin),
    .line_to_dut(serial_in_pin));
  initial forever #10 sys_clk = ~sys_clk;
  // ==========================================================================
  // Shared tasks
  task automatic complete_run();
    if (err_count == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // One strobe cycle; an idle edge first so no strobe is set twice in a step
  task automatic acc(input logic w, input logic [2:0] a, input logic [7:0] d,
                     output logic [7:0] q);
    @(posedge sys_clk);
    #1;
    bus_addr = a;
    bus_wdata = d;
    bus_wr = w;
    bus_rd = !w;
    @(posedge sys_clk);
    #1;
    bus_wr = 1'b0;
    bus_rd = 1'b0;
    q = bus_rdata;
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    logic [7:0] q;
    acc(1'b1, a, d, q);
  endtask
  task automatic rd_chk(input logic [2:0] a, input logic [7:0] exp, input string what);
    logic [7:0] q;
    acc(1'b0, a, 8'h00, q);
    chk(what, q, exp);
  endtask
  task automatic wait_empty();
    logic [7:0] q;
    for (int i = 0; i < 3000; i++) begin
      acc(1'b0, 3'h5, 8'h00, q);
      if (q[6] === 1'b1) return;
    end
    chk("tx_all_empty wait", 16'h0, 16'h1);
    complete_run();
  endtask
  task automatic count_baud_clock_out(output int c);
    c = 0;
    repeat (32) begin
      @(posedge sys_clk);
      #1;
      if (baud_clock_out === 1'b1) c++;
    end
  endtask
  // ==========================================================================
  // Main sequence
  initial begin
    logic [8:0] bits;
    logic [8:0] mask;
    logic ok;
    logic par;
    int stop_cyc, nb, c;
    repeat (10) @(posedge sys_clk);
    #1;
    resetn = 1'b1;
    foreach (ro[i]) rd_chk(ro[i], rv[i], "reset value");
    wr(3'h7, 8'hA5);
    rd_chk(3'h7, 8'hA5, "scratch");
    aen = 1'b1;
    wr(3'h7, 8'h5A);
    rd_chk(3'h3, 8'hA5, "read with aen high");
    aen = 1'b0;
    rd_chk(3'h7, 8'hA5, "scratch after aen");
    wr(3'h1, 8'hFF);
    rd_chk(3'h1, 8'h0F, "interrupt_enables");
    wr(3'h1, 8'h00);
    wr(3'h3, 8'h80);
    wr(3'h0, 8'h34);
    wr(3'h1, 8'h12);
    rd_chk(3'h0, 8'h34, "divisor_low_byte");
    rd_chk(3'h1, 8'h12, "divisor_high_byte");
    wr(3'h0, 8'h01);
    wr(3'h1, 8'h00);
    count_baud_clock_out(c);
    chk("baud out running", c > 0, 1'b1);
    wr(3'h3, 8'h03);
    count_baud_clock_out(c);
    chk("baud out stopped", c, 16'h0);
    rd_chk(3'h0, 8'h00, "receive_buffer");
    rd_chk(3'h3, 8'h03, "line_format");
    foreach (fl[i]) begin
      wait_empty();
      wr(3'h3, fl[i]);
      wr(3'h0, fd[i]);
      nb = 5 + fl[i][1:0];
      mask = (9'h001 << nb) - 9'h001;
      fork
        peer.catch_frame(nb + fl[i][3], bits, stop_cyc, ok);
        wr(3'h0, ~fd[i]);
      join
      chk("frame seen", ok, 1'b1);
      chk("tx data", bits & mask, fd[i] & mask);
      par = fl[i][5] ? ~fl[i][4] : (fl[i][4] ? ^(fd[i] & mask) : ~^(fd[i] & mask));
      if (fl[i][3]) chk("parity bit", bits[nb], par);
      c = !fl[i][2] ? 16 : (nb == 5 ? 24 : 32);
      chk("stop length", stop_cyc >= c - 1 && stop_cyc <= c + 1, 1'b1);
    end
    wait_empty();
    wr(3'h3, 8'h43);
    wr(3'h0, 8'h55);
    chk("break level", serial_out_pin, 1'b0);
    wait_empty();
    chk("break held", serial_out_pin, 1'b0);
    wr(3'h3, 8'h03);
    wr(3'h7, 8'h00);
    chk("break released", serial_out_pin, 1'b1);
    wr(3'h3, 8'h1F);
    peer.send_frame({1'b1, 1'b0, 8'h3C, 1'b0}, 11);
    peer.send_frame({1'b1, 1'b1, 8'h3C, 1'b0}, 11);
    rd_chk(3'h5, 8'h67, "line_state after rx");
    rd_chk(3'h0, 8'h3C, "rx data");
    rd_chk(3'h5, 8'h60, "line_state cleared");
    complete_run();
  end
endmodule // test_uart_line_format_regmap
`default_nettype wire
